// file: hdl/sss_pkg.sv
// Constants and types for the servo stop sequence selector.
// Assumes a single 100 MHz core clock and an APB register bus.
// Contract
// - Servo-off stop selection accepts settings 0 to 9.
// - Settings 0..7 pick brake or free run per phase; 4..7 mirror 0..3.
// - Settings 8, 9 decelerate by emergency stop; then brake (8) or free run (9).
// - Emergency stop torque limit 0..500 percent; zero means normal limit (the code passes zero on unchanged as torqueLimitPct).
// - While stopping or stopped, force position control and halt command generation.
// - Clear deviation in both phases by tracking command to feedback.
// - Deceleration ends below 30 r/min; then stopped regardless of speed.
// - Alarm during servo-off uses alarm selection; power loss uses power-loss selection.
// - Power-loss stop selection accepts settings 0 to 9.
// - Trip bit 0 clear: servo-off, resume on power return; set: trip error 13.1.
// - Trip bit 1 clear: detect only while servo on; set: detect always.
// - Raise power-off alarm only when power stays lost longer than detect time.
// - Detect time 70..2000 ms, 2 ms resolution; 2000 disables detection.
// - An alarm while main power is off uses the alarm stop selection.
package sss_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 2;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] STOP_SPEED_RPM = 16'd30;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam logic [2:0] ALARM_SEL_MAX = 3'h7;
    localparam logic [9:0] TORQUE_MAX = 10'h1f4;
    localparam logic [11:0] DETECT_MIN_MS = 12'h046;
    localparam logic [11:0] DETECT_OFF_MS = 12'h7d0;
    localparam logic [3:0] SEL_ESTOP_DB = 4'h8;
    localparam logic [3:0] SEL_ESTOP_FREE = 4'h9;
    localparam int SEL_DECEL_BIT = 0;
    localparam int SEL_STOP_BIT = 1;
    localparam int TRIP_BIT = 0;
    localparam int ALWAYS_BIT = 1;
    localparam logic [7:0] UV_ERR_MAIN = 8'h0d;
    localparam logic [3:0] UV_ERR_SUB = 4'h1;
    // Register byte offsets
    localparam logic [7:0] OFS_SERVO_SEL = 8'h00;
    localparam logic [7:0] OFS_POWER_SEL = 8'h04;
    localparam logic [7:0] OFS_TRIP_SEL = 8'h08;
    localparam logic [7:0] OFS_DETECT_TIME = 8'h0c;
    localparam logic [7:0] OFS_ALARM_SEL = 8'h10;
    localparam logic [7:0] OFS_ESTOP_TORQUE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_CONTROL = 8'h24;
    // Reset value, interrupt count and interrupt bit positions
    localparam logic [11:0] DETECT_RESET = 12'h046;
    localparam int IRQ_BITS = 4;
    localparam int IRQ_STOPPED = 0;
    localparam int IRQ_PWR_ALARM = 1;
    localparam int IRQ_UV_TRIP = 2;
    localparam int IRQ_PWR_BACK = 3;
    typedef enum logic [1:0] {BRK_DB, BRK_FREE, BRK_ESTOP} sss_brake_t;
    typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_STOPPED} sss_state_t;
endpackage

// file: hdl/sss_apb_regs.sv
// APB slave holding the stop sequence settings and interrupt registers.
// Assumes APB3 timing; answers with zero wait states.
`timescale 1ns/1ps
module sss_apb_regs
    import sss_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [IRQ_BITS-1:0] irqEvents,
    input wire logic [7:0] statusWord,
    output logic [3:0] servoOffSel,
    output logic [3:0] powerLossSel,
    output logic [1:0] tripSel,
    output logic [11:0] detectTime,
    output logic [2:0] alarmSel,
    output logic [9:0] estopTorque,
    output logic clearTrip,
    output logic irq
);
    logic [IRQ_BITS-1:0] irqStatus_q;
    logic [IRQ_BITS-1:0] irqMask_q;
    logic wrEn;
    logic mapped;

    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;

    always_comb begin
        mapped = 1'b1;
        prdata = 32'h0;
        case (paddr)
            OFS_SERVO_SEL: prdata[3:0] = servoOffSel;
            OFS_POWER_SEL: prdata[3:0] = powerLossSel;
            OFS_TRIP_SEL: prdata[1:0] = tripSel;
            OFS_DETECT_TIME: prdata[11:0] = detectTime;
            OFS_ALARM_SEL: prdata[2:0] = alarmSel;
            OFS_ESTOP_TORQUE: prdata[9:0] = estopTorque;
            OFS_STATUS: prdata[7:0] = statusWord;
            OFS_IRQ_STATUS: prdata[IRQ_BITS-1:0] = irqStatus_q;
            OFS_IRQ_MASK: prdata[IRQ_BITS-1:0] = irqMask_q;
            OFS_CONTROL: prdata = 32'h0;
            default: mapped = 1'b0;
        endcase
    end

    // Out-of-range settings are refused so the selectors never see them
    assign pslverr = psel && penable && (!mapped || (pwrite && (
        (paddr == OFS_SERVO_SEL && pwdata[3:0] > SEL_MAX) ||
        (paddr == OFS_POWER_SEL && pwdata[3:0] > SEL_MAX) ||
        (paddr == OFS_ESTOP_TORQUE && pwdata[9:0] > TORQUE_MAX) ||
        (paddr == OFS_DETECT_TIME && (pwdata[11:0] < DETECT_MIN_MS ||
            pwdata[11:0] > DETECT_OFF_MS)))));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            servoOffSel <= 4'h0;
            powerLossSel <= 4'h0;
            tripSel <= 2'h0;
            detectTime <= DETECT_RESET;
            alarmSel <= 3'h0;
            estopTorque <= 10'h0;
            irqMask_q <= '0;
        end else if (wrEn && !pslverr) begin
            case (paddr)
                OFS_SERVO_SEL: servoOffSel <= pwdata[3:0];
                OFS_POWER_SEL: powerLossSel <= pwdata[3:0];
                OFS_TRIP_SEL: tripSel <= pwdata[1:0];
                OFS_DETECT_TIME: detectTime <= pwdata[11:0];
                OFS_ALARM_SEL: alarmSel <= pwdata[2:0];
                OFS_ESTOP_TORQUE: estopTorque <= pwdata[9:0];
                OFS_IRQ_MASK: irqMask_q <= pwdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    assign clearTrip = wrEn && paddr == OFS_CONTROL && pwdata[0];

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqStatus_q <= '0;
        end else begin
            irqStatus_q <= (irqStatus_q & ~((wrEn && paddr == OFS_IRQ_STATUS) ?
                pwdata[IRQ_BITS-1:0] : '0)) | irqEvents;
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);
endmodule

// file: hdl/sss_loss_timer.sv
// Main power loss detection timer counting in 2 ms ticks.
// Assumes mainPowerOk is synchronous to core_clk.
`timescale 1ns/1ps
module sss_loss_timer
    import sss_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic mainPowerOk,
    input wire logic armed,
    input wire logic [11:0] detectTime,
    output logic lossDetected
);
    logic [$clog2(TICK_LEN+1)-1:0] tickCnt_q;
    logic [10:0] tickNum_q;
    logic [10:0] limitTicks;
    logic running;

    // Odd ms settings round up to the next tick
    assign limitTicks = 11'((detectTime + 12'h1) >> 1);
    assign running = !mainPowerOk && armed && detectTime != DETECT_OFF_MS;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_q <= '0;
            tickNum_q <= '0;
        end else if (!running) begin
            tickCnt_q <= '0;
            tickNum_q <= '0;
        end else if (tickCnt_q == ($bits(tickCnt_q))'(TICK_LEN - 1)) begin
            tickCnt_q <= '0;
            if (tickNum_q <= limitTicks)
                tickNum_q <= tickNum_q + 11'h1;
        end else begin
            tickCnt_q <= tickCnt_q + 1'b1;
        end
    end

    // Strictly longer than the setting
    assign lossDetected = running && tickNum_q > limitTicks;

    a_loss_needs_time: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(lossDetected) |-> $past(running, 2))
        else $error("loss flagged without a running timer");
    a_loss_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
        detectTime == DETECT_OFF_MS |-> !lossDetected)
        else $error("loss flagged with detection disabled");
endmodule

// file: hdl/sss_stop_selector.sv
// Top of the stop sequence selector: picks braking per phase on stop events.
// Assumes speed, power and command inputs are synchronous to core_clk.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module sss_stop_selector
    import sss_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic servoOnCmd,
    input wire logic mainPowerOk,
    input wire logic alarmActive,
    input wire logic [15:0] motorSpeedRpm,
    input wire logic [31:0] feedbackPos,
    output logic servoEnergised,
    output logic dynamicBrakeOn,
    output logic torqueLimitEstop,
    output logic [9:0] torqueLimitPct,
    output logic forcePositionMode,
    output logic haltCmdGen,
    output logic deviationClear,
    output logic [31:0] commandPos,
    output logic uvTrip,
    output logic [7:0] errMain,
    output logic [3:0] errSub
);
    logic [3:0] servoOffSel;
    logic [3:0] powerLossSel;
    logic [1:0] tripSel;
    logic [11:0] detectTime;
    logic [2:0] alarmSel;
    logic [9:0] estopTorque;
    logic clearTrip;
    logic lossDetected;
    logic powerOff_q;
    logic servoOn_q;
    logic stopping;
    logic stopReq;
    logic belowStop;
    sss_state_t state_q;
    sss_brake_t decelMode;
    sss_brake_t stopMode;
    logic [7:0] statusWord;
    logic [IRQ_BITS-1:0] irqEvents;
    logic [3:0] activeSel;

    sss_apb_regs u_regs (
        .core_clk(core_clk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irqEvents(irqEvents),
        .statusWord(statusWord),
        .servoOffSel(servoOffSel),
        .powerLossSel(powerLossSel),
        .tripSel(tripSel),
        .detectTime(detectTime),
        .alarmSel(alarmSel),
        .estopTorque(estopTorque),
        .clearTrip(clearTrip),
        .irq(irq)
    );

    sss_loss_timer #(
        .TICK_LEN(TICK_LEN)
    ) u_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .mainPowerOk(mainPowerOk),
        .armed(tripSel[ALWAYS_BIT] || servoOn_q),
        .detectTime(detectTime),
        .lossDetected(lossDetected)
    );

    // Power-loss state is held once detected, until power returns
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powerOff_q <= 1'b0;
        end else if (mainPowerOk) begin
            powerOff_q <= 1'b0;
        end else if (lossDetected) begin
            powerOff_q <= 1'b1;
        end
    end

    // Trip is sticky until software clears it; a new trip wins over the clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            uvTrip <= 1'b0;
        end else if (lossDetected && tripSel[TRIP_BIT]) begin
            uvTrip <= 1'b1;
        end else if (clearTrip) begin
            uvTrip <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            errMain <= 8'h0;
            errSub <= 4'h0;
        end else begin
            errMain <= (lossDetected && tripSel[TRIP_BIT]) || uvTrip ? UV_ERR_MAIN : 8'h0;
            errSub <= (lossDetected && tripSel[TRIP_BIT]) || uvTrip ? UV_ERR_SUB : 4'h0;
        end
    end

    // Alarm or trip beats power loss, which beats a plain servo-off
    always_comb begin
        if (alarmActive || uvTrip) begin
            activeSel = {1'b0, alarmSel};
        end else if (powerOff_q) begin
            activeSel = powerLossSel;
        end else begin
            activeSel = servoOffSel;
        end
    end

    assign stopReq = !servoOnCmd || alarmActive || uvTrip || powerOff_q;
    assign belowStop = motorSpeedRpm < STOP_SPEED_RPM;

    // Alarm table values 4..7 map onto the plain 0..3 behaviour here
    always_comb begin
        if (activeSel == SEL_ESTOP_DB || activeSel == SEL_ESTOP_FREE) begin
            decelMode = BRK_ESTOP;
            stopMode = activeSel == SEL_ESTOP_DB ? BRK_DB : BRK_FREE;
        end else begin
            decelMode = activeSel[SEL_DECEL_BIT] ? BRK_FREE : BRK_DB;
            stopMode = activeSel[SEL_STOP_BIT] ? BRK_FREE : BRK_DB;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_STOPPED;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (stopReq)
                        state_q <= belowStop ? ST_STOPPED : ST_DECEL;
                end
                ST_DECEL: begin
                    if (belowStop)
                        state_q <= ST_STOPPED;
                end
                ST_STOPPED: begin
                    if (!stopReq)
                        state_q <= ST_RUN;
                end
                default: state_q <= ST_STOPPED;
            endcase
        end
    end

    assign stopping = state_q != ST_RUN;
    assign servoOn_q = state_q == ST_RUN;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            servoEnergised <= 1'b0;
            dynamicBrakeOn <= 1'b0;
            torqueLimitEstop <= 1'b0;
            torqueLimitPct <= 10'h0;
            forcePositionMode <= 1'b0;
            haltCmdGen <= 1'b0;
            deviationClear <= 1'b0;
        end else begin
            forcePositionMode <= stopping;
            haltCmdGen <= stopping;
            deviationClear <= stopping;
            torqueLimitEstop <= state_q == ST_DECEL && decelMode == BRK_ESTOP;
            torqueLimitPct <= estopTorque;
            servoEnergised <= !stopping || (state_q == ST_DECEL && decelMode == BRK_ESTOP);
            if (state_q == ST_DECEL)
                dynamicBrakeOn <= decelMode == BRK_DB;
            else if (state_q == ST_STOPPED)
                dynamicBrakeOn <= stopMode == BRK_DB;
            else
                dynamicBrakeOn <= 1'b0;
        end
    end

    // Command follows feedback so no deviation builds up while stopping
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            commandPos <= 32'h0;
        end else if (stopping) begin
            commandPos <= feedbackPos;
        end
    end

    assign statusWord = {2'b00, uvTrip, powerOff_q, dynamicBrakeOn, servoEnergised,
        state_q == ST_STOPPED, state_q == ST_DECEL};
    always_comb begin
        irqEvents = '0;
        irqEvents[IRQ_STOPPED] = state_q == ST_DECEL && belowStop;
        irqEvents[IRQ_PWR_ALARM] = lossDetected && !powerOff_q;
        irqEvents[IRQ_UV_TRIP] = lossDetected && tripSel[TRIP_BIT] && !uvTrip;
        irqEvents[IRQ_PWR_BACK] = powerOff_q && mainPowerOk;
    end

    a_decel_to_stop: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_DECEL && belowStop |=> state_q == ST_STOPPED)
        else $error("deceleration did not end below stop speed");
    a_stopped_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_STOPPED && stopReq |=> state_q == ST_STOPPED)
        else $error("left stop state while stop requested");
    a_force_position: assert property (@(posedge core_clk) disable iff (!rstn)
        stopping |=> forcePositionMode && haltCmdGen && deviationClear)
        else $error("position mode not forced while stopping");
    a_track_feedback: assert property (@(posedge core_clk) disable iff (!rstn)
        stopping |=> commandPos == $past(feedbackPos))
        else $error("command position not tracking feedback");
    a_estop_decel: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_DECEL && activeSel == SEL_ESTOP_FREE
        |=> torqueLimitEstop && servoEnergised && !dynamicBrakeOn)
        else $error("emergency stop not applied");
    a_stop_brake: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == ST_STOPPED && activeSel < SEL_ESTOP_DB
        |=> dynamicBrakeOn == !$past(activeSel[SEL_STOP_BIT]))
        else $error("after-stop brake does not match selection");
    a_alarm_priority: assert property (@(posedge core_clk) disable iff (!rstn)
        alarmActive |-> activeSel == {1'b0, alarmSel})
        else $error("alarm selection not applied");
    a_trip_sets: assert property (@(posedge core_clk) disable iff (!rstn)
        lossDetected && tripSel[TRIP_BIT] |=> uvTrip && errMain == UV_ERR_MAIN)
        else $error("undervoltage trip not raised");
endmodule

// file: verification/sss_host_model.sv
// Upper motion controller model: commands servo on/off, keeps its own coordinate.
// Assumes the drive's registered outputs, all on core_clk.
`timescale 1ns/1ps
module sss_host_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wantOn,
    input wire logic servoEnergised,
    input wire logic [31:0] commandPos,
    output logic servoOnCmd,
    output logic [31:0] hostCoord
);
    logic wasOn_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            servoOnCmd <= 1'b0;
            hostCoord <= 32'h0;
            wasOn_q <= 1'b0;
        end else begin
            servoOnCmd <= wantOn;
            wasOn_q <= servoEnergised;
            // Re-sync before any feed, else the motor would jump
            if (servoEnergised && !wasOn_q) begin
                hostCoord <= commandPos;
            end
        end
    end
endmodule

// file: verification/tb.sv
// Self-checking bench for the stop sequence selector, APB master and host model.
// Assumes TICK_LEN shortened to 4 cycles so detection times stay short.
`timescale 1ns/1ps
module tb;
    import sss_pkg::*;
    localparam int TL = 4;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, commandPos, hostCoord, rdata;
    logic [31:0] feedbackPos = 32'h0;
    logic [15:0] motorSpeedRpm = 16'h0;
    logic pready, pslverr, irq, servoOnCmd, servoEnergised, dynamicBrakeOn, torqueLimitEstop;
    logic forcePositionMode, haltCmdGen, deviationClear, uvTrip;
    logic wantOn = 0, mainPowerOk = 1, alarmActive = 0;
    logic [9:0] torqueLimitPct;
    logic [7:0] errMain;
    logic [3:0] errSub;
    int n_checks = 0, n_mismatch = 0, det = 70, dly;
    logic [31:0] seed = 32'd77265;

    always #5 core_clk = ~core_clk;

    sss_stop_selector #(.TICK_LEN(TL)) sss_stop_selector_inst (.core_clk(core_clk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .servoOnCmd(servoOnCmd), .mainPowerOk(mainPowerOk), .alarmActive(alarmActive),
        .motorSpeedRpm(motorSpeedRpm), .feedbackPos(feedbackPos),
        .servoEnergised(servoEnergised), .dynamicBrakeOn(dynamicBrakeOn),
        .torqueLimitEstop(torqueLimitEstop), .torqueLimitPct(torqueLimitPct),
        .forcePositionMode(forcePositionMode), .haltCmdGen(haltCmdGen),
        .deviationClear(deviationClear), .commandPos(commandPos), .uvTrip(uvTrip),
        .errMain(errMain), .errSub(errSub));
    sss_host_model sss_host_model_inst (.core_clk(core_clk), .rstn(rstn), .wantOn(wantOn),
        .servoEnergised(servoEnergised), .commandPos(commandPos),
        .servoOnCmd(servoOnCmd), .hostCoord(hostCoord));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected {estop, brake, energised} for a selection and phase
    function automatic logic [2:0] exp_out(input logic [3:0] sel, input bit stopped);
        if (sel >= 4'h8) begin
            return stopped ? {1'b0, sel == 4'h8, 1'b0} : 3'b101;
        end
        return {1'b0, ~(stopped ? sel[1] : sel[0]), 1'b0};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen at an edge
    task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        check("pslverr", {31'h0, pslverr}, {31'h0, e});
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the stored value settle before any caller looks at outputs
        @(posedge core_clk);
    endtask

    task automatic run_up();
        wantOn <= 1'b1;
        motorSpeedRpm <= 16'd100;
        cyc(5);
        check("energised", servoEnergised, 1);
        check("hostcoord", hostCoord, feedbackPos);
    endtask

    task automatic phase_chk(input logic [3:0] sel, input bit stopped);
        logic [2:0] e;
        e = exp_out(sel, stopped);
        check("estop", torqueLimitEstop, e[2]);
        check("brake", dynamicBrakeOn, e[1]);
        check("energised", servoEnergised, e[0]);
        check("torque", torqueLimitPct, 10'd500);
        check("posmode", {forcePositionMode, haltCmdGen}, 2'b11);
        check("devclr", deviationClear, 1);
        check("cmdpos", commandPos, feedbackPos);
    endtask

    // Cause: 0 servo-off, 1 alarm, 2 main power loss
    task automatic stop_case(input logic [3:0] sel, input int cause);
        run_up();
        feedbackPos <= rnd();
        motorSpeedRpm <= 16'd30 + 16'(rnd() & 32'hff);
        dly = ((det + 1) / 2 + 1) * TL;
        if (cause == 0) wantOn <= 1'b0;
        if (cause == 1) alarmActive <= 1'b1;
        if (cause == 2) begin
            mainPowerOk <= 1'b0;
            cyc(dly - 6);
            check("early", servoEnergised, 1);
            cyc(10);
        end
        cyc(3);
        motorSpeedRpm <= 16'd30;
        cyc(3);
        phase_chk(sel, 0);
        motorSpeedRpm <= 16'd29;
        cyc(3);
        phase_chk(sel, 1);
        motorSpeedRpm <= 16'd200;
        cyc(3);
        phase_chk(sel, 1);
        alarmActive <= 1'b0;
        mainPowerOk <= 1'b1;
        $display("test stop sel %0d cause %0d done", sel, cause);
    endtask

    initial begin
        cyc(6);
        rstn <= 1'b1;
        cyc(2);
        reg_io(0, OFS_DETECT_TIME, 0, 0);
        check("detect reset", rdata, 32'd70);
        reg_io(1, OFS_SERVO_SEL, 10, 1);
        reg_io(1, OFS_POWER_SEL, 10, 1);
        reg_io(1, OFS_ESTOP_TORQUE, 501, 1);
        reg_io(1, OFS_ESTOP_TORQUE, 500, 0);
        reg_io(1, OFS_DETECT_TIME, 69, 1);
        reg_io(1, OFS_DETECT_TIME, 2001, 1);
        reg_io(0, 8'h40, 0, 1);
        check("unmapped", rdata, 0);
        $display("test registers done");
        for (int s = 0; s <= 9; s++) begin
            reg_io(1, OFS_SERVO_SEL, s, 0);
            stop_case(4'(s), 0);
        end
        reg_io(1, OFS_SERVO_SEL, 1, 0);
        reg_io(1, OFS_ALARM_SEL, 6, 0);
        stop_case(4'h6, 1);
        reg_io(1, OFS_POWER_SEL, 9, 0);
        stop_case(4'h9, 2);
        check("irq masked", irq, 0);
        reg_io(1, OFS_IRQ_MASK, 32'h2, 0);
        check("irq", irq, 1);
        reg_io(1, OFS_IRQ_STATUS, 32'h2, 0);
        check("irq cleared", irq, 0);
        run_up();
        det = 71;
        reg_io(1, OFS_DETECT_TIME, 71, 0);
        stop_case(4'h9, 2);
        reg_io(1, OFS_TRIP_SEL, 1, 0);
        reg_io(1, OFS_IRQ_MASK, 32'h4, 0);
        run_up();
        mainPowerOk <= 1'b0;
        cyc(dly - 8);
        mainPowerOk <= 1'b1;
        cyc(2);
        mainPowerOk <= 1'b0;
        cyc(dly - 8);
        check("restart", uvTrip, 0);
        cyc(20);
        check("trip", {uvTrip, errMain, errSub}, {1'b1, 8'h0d, 4'h1});
        check("irq trip", irq, 1);
        mainPowerOk <= 1'b1;
        reg_io(1, OFS_IRQ_STATUS, 32'h4, 0);
        reg_io(1, OFS_CONTROL, 1, 0);
        check("untrip", {uvTrip, irq}, 2'b00);
        wantOn <= 1'b0;
        cyc(5);
        mainPowerOk <= 1'b0;
        cyc(dly + 12);
        check("off no detect", uvTrip, 0);
        reg_io(1, OFS_TRIP_SEL, 3, 0);
        cyc(dly + 12);
        check("always detect", uvTrip, 1);
        mainPowerOk <= 1'b1;
        reg_io(1, OFS_CONTROL, 1, 0);
        reg_io(1, OFS_DETECT_TIME, 2000, 0);
        mainPowerOk <= 1'b0;
        cyc(1100 * TL);
        check("disabled", uvTrip, 0);
        $display("test power loss done");
        end_of_test();
    end

    initial begin
        cyc(60000);
        n_mismatch++;
        end_of_test();
    end
endmodule
